/* File: rtl/adcc_defines.svh */
// Register indices, field positions, reset values and timing counts for the converter control block.
// Included by bare name from every design file that needs them; it holds definitions only.
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH

// Register indices; the byte address on the bus is four times the index.
`define ADCC_IDX_PORT    8'h06
`define ADCC_IDX_STATUS  8'h0C
`define ADCC_IDX_RESULT  8'h1E
`define ADCC_IDX_CTRL    8'h1F
`define ADCC_IDX_PINCFG  8'h9F

// Fields of converter_control.
`define ADCC_CLKSEL_HI   7
`define ADCC_CLKSEL_LO   6
`define ADCC_CHAN_HI     4
`define ADCC_CHAN_LO     3
`define ADCC_BUSY_BIT    2
`define ADCC_POWER_BIT   0
`define ADCC_CTRL_WMASK  8'hDD
`define ADCC_CLK_RC      2'h3

// Fields of the status register.
`define ADCC_ST_FLAG     0
`define ADCC_ST_IRQEN    1
`define ADCC_ST_PINCHG   2
`define ADCC_ST_EXTIRQ   3
`define ADCC_ST_OFF      4

// Reset values.
`define ADCC_CTRL_RST    8'h00
`define ADCC_PINCFG_RST  3'h0

// Oscillator divide ratios per bit period, and the derived half-period reload.
`define ADCC_DIV_A       2
`define ADCC_DIV_B       8
`define ADCC_DIV_C       32
`define ADCC_HALF_A      4'((`ADCC_DIV_A / 2) - 1)
`define ADCC_HALF_B      4'((`ADCC_DIV_B / 2) - 1)
`define ADCC_HALF_C      4'((`ADCC_DIV_C / 2) - 1)

// Sequence lengths in half bit periods, and the instruction-cycle wait in clocks.
`define ADCC_CONV_HALVES 5'd19
`define ADCC_HOLD_HALVES 5'd4
`define ADCC_INSTR_TOSC  5'd4

`endif

/* File: rtl/adcc_pkg.sv */
// Types shared by the converter control block: sequencer states and the state records.
// Assumes nothing of its surroundings.
package adcc_pkg;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_RCWAIT = 2'b01,
        ST_CONV   = 2'b10,
        ST_HOLD   = 2'b11
    } adcc_state_e;

    typedef struct packed {
        logic       rc1;
        logic       rc2;
        logic       rc3;
        logic       rc_val;
        logic [3:0] div;
        logic       tick;
    } adcc_tick_s;

    typedef struct packed {
        logic        ack;
        logic [7:0]  rd;
        logic [7:0]  ctrl;
        logic [2:0]  port_config;
        logic [7:0]  result;
        logic        flag;
        logic        irq_en;
        logic        pin_flag;
        logic        ext_flag;
        logic        sleep_off;
        adcc_state_e state;
        logic [4:0]  cnt;
        logic [2:0]  bidx;
        logic [7:0]  dac;
        logic        wake;
        logic [3:0]  pin_s1;
        logic [3:0]  pin_s2;
        logic [3:0]  pin_s3;
        logic [3:0]  pin_val;
    } adcc_top_s;

endpackage

/* File: rtl/adcc_bit_clock.sv */
// Half bit-period tick generator for the converter sequencer.
// Assumes sys_clk is the device oscillator and rc_clk a free RC clock from outside this domain.
`include "adcc_defines.svh"

module adcc_bit_clock (
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic [1:0] clk_sel,
    input  wire logic       run,
    input  wire logic       rc_clk,
    output logic            half_tick
);

    adcc_pkg::adcc_tick_s st;
    adcc_pkg::adcc_tick_s next_st;
    logic [3:0]           lim;

    // Reload value for the oscillator divider, one half bit period long.
    always_comb begin
        if (clk_sel == 2'h0) begin
            lim = `ADCC_HALF_A;
        end else if (clk_sel == 2'h1) begin
            lim = `ADCC_HALF_B;
        end else begin
            lim = `ADCC_HALF_C;
        end
    end

    // Each settled RC edge is one half period; the divider is held while idle so the first tick is full length.
    always_comb begin
        next_st        = st;
        next_st.rc1    = rc_clk;
        next_st.rc2    = st.rc1;
        next_st.rc3    = st.rc2;
        next_st.tick   = 1'b0;
        if (st.rc2 == st.rc3) begin
            next_st.rc_val = st.rc3;
        end
        if (clk_sel == `ADCC_CLK_RC) begin
            next_st.div  = 4'h0;
            next_st.tick = run & (st.rc2 == st.rc3) & (st.rc3 != st.rc_val);
        end else if (!run) begin
            next_st.div = 4'h0;
        end else if (st.div >= lim) begin
            next_st.div  = 4'h0;
            next_st.tick = 1'b1;
        end else begin
            next_st.div = st.div + 4'h1;
        end
    end

    // State register.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign half_tick = st.tick;

endmodule

/* File: rtl/adcc_top.sv */
// Control logic of a four-input 8-bit successive-approximation converter with its register file.
// Assumes an Avalon-MM master on SYS_CLK, an analog comparator and trial DAC outside, and a CPU sleep level.
//
// Local design decision: register access over Avalon-MM.
`include "adcc_defines.svh"

module adcc_top (
    input  wire logic        SYS_CLK,
    input  wire logic        RESET_N,
    input  wire logic [9:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic [31:0]      AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic        SLEEP,
    input  wire logic        RC_CLK,
    input  wire logic        COMP_IN,
    input  wire logic [3:0]  PIN_IN,
    output logic             ANALOG_ENABLE,
    output logic             SAMPLE,
    output logic [1:0]       CHANNEL,
    output logic [7:0]       DAC_CODE,
    output logic [3:0]       ANALOG_PINS,
    output logic             REF_FROM_PIN,
    output logic             WAKE
);

    adcc_pkg::adcc_top_s st;
    adcc_pkg::adcc_top_s next_st;
    logic                half_tick;
    logic                req;
    logic                take;
    logic                active;
    logic                done;
    logic [7:0]          idx;
    logic [7:0]          dac_dec;
    logic [7:0]          bit_mask;
    logic [4:0]          cur_cfg;
    logic [4:0]          new_cfg;
    logic [3:0]          port_read;

    // Pin configuration decode: {reference from pin, analog inputs GP4..GP0 order bits 3..0}.
    function automatic logic [4:0] cfg_decode(input logic [2:0] code);
        logic [4:0] r;
        r = 5'h00;
        if (code == 3'h0) begin
            r = 5'h0F;
        end else if (code == 3'h1) begin
            r = 5'h1D;
        end else if (code == 3'h2) begin
            r = 5'h07;
        end else if (code == 3'h3) begin
            r = 5'h15;
        end else if (code == 3'h4) begin
            r = 5'h03;
        end else if (code == 3'h5) begin
            r = 5'h11;
        end else if (code == 3'h6) begin
            r = 5'h01;
        end else begin
            r = 5'h00;
        end
        return r;
    endfunction

    adcc_bit_clock u_bit_clock (
        .sys_clk   (SYS_CLK),
        .reset_n   (RESET_N),
        .clk_sel   (st.ctrl[`ADCC_CLKSEL_HI:`ADCC_CLKSEL_LO]),
        .run       (st.state != adcc_pkg::ST_IDLE),
        .rc_clk    (RC_CLK),
        .half_tick (half_tick)
    );

    // Bus handshake: every access takes exactly one wait state, so read data can be registered.
    assign req             = AVS_READ | AVS_WRITE;
    assign take            = req & st.ack;
    assign AVS_WAITREQUEST = req & ~st.ack;
    assign idx             = AVS_ADDRESS[9:2];

    // Shared decodes used by the sequencer and the register file.
    assign active    = st.ctrl[`ADCC_POWER_BIT] & ~st.sleep_off;
    assign bit_mask  = 8'h01 << st.bidx;
    // The comparator answers the trial code that this block drives, so it is read directly.
    // Three synchroniser flops would outlast one half bit period at the fastest divider.
    assign dac_dec   = COMP_IN ? st.dac : (st.dac & ~bit_mask);
    assign done      = (st.state == adcc_pkg::ST_CONV) & half_tick & (st.cnt == `ADCC_CONV_HALVES - 5'd1);
    assign cur_cfg   = cfg_decode(st.port_config);
    assign new_cfg   = cfg_decode(AVS_WRITEDATA[2:0]);
    assign port_read = st.pin_val & ~(cur_cfg[3:0] | {2'h0, cur_cfg[4], 1'b0});

    // Next state. Software writes are applied first so that hardware events land on top and win.
    always_comb begin
        next_st        = st;
        next_st.ack    = req & ~st.ack;
        next_st.wake   = 1'b0;
        next_st.pin_s1 = PIN_IN;
        next_st.pin_s2 = st.pin_s1;
        next_st.pin_s3 = st.pin_s2;
        next_st.pin_val = (st.pin_s2 & st.pin_s3) | (st.pin_val & (st.pin_s2 ^ st.pin_s3));

        // Read data is captured in the wait cycle and stands in the cycle the access completes.
        if (AVS_READ & ~st.ack) begin
            if (idx == `ADCC_IDX_CTRL) begin
                next_st.rd = st.ctrl;
            end else if (idx == `ADCC_IDX_PINCFG) begin
                next_st.rd = {5'h00, st.port_config};
            end else if (idx == `ADCC_IDX_RESULT) begin
                next_st.rd = st.result;
            end else if (idx == `ADCC_IDX_PORT) begin
                next_st.rd = {4'h0, port_read};
            end else if (idx == `ADCC_IDX_STATUS) begin
                next_st.rd = {3'h0, st.sleep_off, st.ext_flag, st.pin_flag, st.irq_en, st.flag};
            end else begin
                next_st.rd = 8'h00;
            end
        end

        // Register writes on the completing edge; unmapped writes are dropped.
        if (take & AVS_WRITE & AVS_BYTEENABLE[0]) begin
            if (idx == `ADCC_IDX_CTRL) begin
                next_st.ctrl = AVS_WRITEDATA[7:0] & `ADCC_CTRL_WMASK;
                if (!AVS_WRITEDATA[`ADCC_POWER_BIT]) begin
                    next_st.ctrl[`ADCC_BUSY_BIT] = 1'b0;
                end
            end else if (idx == `ADCC_IDX_PINCFG) begin
                next_st.port_config = AVS_WRITEDATA[2:0];
                if (new_cfg != cur_cfg) begin
                    next_st.pin_flag = 1'b1;
                end
                if (new_cfg[0] != cur_cfg[0]) begin
                    next_st.ext_flag = 1'b1;
                end
            end else if (idx == `ADCC_IDX_RESULT) begin
                next_st.result = AVS_WRITEDATA[7:0];
            end else if (idx == `ADCC_IDX_STATUS) begin
                next_st.flag     = AVS_WRITEDATA[`ADCC_ST_FLAG];
                next_st.irq_en   = AVS_WRITEDATA[`ADCC_ST_IRQEN];
                next_st.pin_flag = AVS_WRITEDATA[`ADCC_ST_PINCHG];
                next_st.ext_flag = AVS_WRITEDATA[`ADCC_ST_EXTIRQ];
            end
        end

        // Leaving sleep brings a converter that sleep switched off back to life.
        if (!SLEEP) begin
            next_st.sleep_off = 1'b0;
        end

        // Conversion sequencer.
        case (st.state)
            adcc_pkg::ST_IDLE: begin
                next_st.cnt  = 5'd0;
                next_st.bidx = 3'd7;
                if (active & next_st.ctrl[`ADCC_BUSY_BIT]) begin
                    next_st.dac = 8'h00;
                    if (next_st.ctrl[`ADCC_CLKSEL_HI:`ADCC_CLKSEL_LO] == `ADCC_CLK_RC) begin
                        next_st.state = adcc_pkg::ST_RCWAIT;
                    end else begin
                        next_st.state = adcc_pkg::ST_CONV;
                    end
                end
            end
            adcc_pkg::ST_RCWAIT: begin
                // The wait lets a sleep request land before any switching starts.
                if (st.cnt == `ADCC_INSTR_TOSC - 5'd1) begin
                    next_st.cnt   = 5'd0;
                    next_st.state = adcc_pkg::ST_CONV;
                end else begin
                    next_st.cnt = st.cnt + 5'd1;
                end
            end
            adcc_pkg::ST_CONV: begin
                if (SLEEP & (st.ctrl[`ADCC_CLKSEL_HI:`ADCC_CLKSEL_LO] != `ADCC_CLK_RC)) begin
                    next_st.sleep_off             = 1'b1;
                    next_st.ctrl[`ADCC_BUSY_BIT]  = 1'b0;
                    next_st.state                 = adcc_pkg::ST_IDLE;
                end else if (done) begin
                    next_st.result                = dac_dec;
                    next_st.ctrl[`ADCC_BUSY_BIT]  = 1'b0;
                    next_st.flag                  = 1'b1;
                    next_st.dac                   = dac_dec;
                    next_st.cnt                   = 5'd0;
                    next_st.state                 = adcc_pkg::ST_HOLD;
                    if (SLEEP & st.irq_en) begin
                        next_st.wake = 1'b1;
                    end else if (SLEEP) begin
                        next_st.sleep_off = 1'b1;
                    end
                end else if (half_tick) begin
                    // The first three halves pass with SAMPLE already low; then each bit is set, then judged.
                    next_st.cnt = st.cnt + 5'd1;
                    if (st.cnt >= 5'd3 && st.cnt[0]) begin
                        next_st.dac = st.dac | bit_mask;
                    end else if (st.cnt >= 5'd4 && !st.cnt[0]) begin
                        next_st.dac  = dac_dec;
                        next_st.bidx = st.bidx - 3'd1;
                    end
                end
            end
            adcc_pkg::ST_HOLD: begin
                if (half_tick) begin
                    next_st.cnt = st.cnt + 5'd1;
                    if (st.cnt == `ADCC_HOLD_HALVES - 5'd1) begin
                        next_st.state = adcc_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                next_st.state = adcc_pkg::ST_IDLE;
            end
        endcase

        // A software clear of busy during the wait or the conversion aborts without touching the result.
        if ((st.state == adcc_pkg::ST_RCWAIT || st.state == adcc_pkg::ST_CONV) &&
            !next_st.ctrl[`ADCC_BUSY_BIT] && !done && !next_st.sleep_off) begin
            next_st.cnt   = 5'd0;
            next_st.state = adcc_pkg::ST_HOLD;
        end

        // Power off overrides the state and busy bit set above and parks the sequencer; a same-cycle completion's result and flag stand.
        if (!next_st.ctrl[`ADCC_POWER_BIT]) begin
            next_st.ctrl[`ADCC_BUSY_BIT] = 1'b0;
            next_st.state                = adcc_pkg::ST_IDLE;
        end
    end

    // State register; the all-zero reset is the documented off, /2, channel zero, all-analog state.
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs. The sampler stays on the pin while the converter is active and idle; nothing ever discharges the hold capacitor.
    assign AVS_READDATA  = {24'h000000, st.rd};
    assign ANALOG_ENABLE = active;
    assign SAMPLE        = active & (st.state == adcc_pkg::ST_IDLE);
    assign CHANNEL       = st.ctrl[`ADCC_CHAN_HI:`ADCC_CHAN_LO];
    assign DAC_CODE      = st.dac;
    assign ANALOG_PINS   = cur_cfg[3:0];
    assign REF_FROM_PIN  = cur_cfg[4];
    assign WAKE          = st.wake;

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESET_N);

    property p_busy_needs_power;
        st.ctrl[`ADCC_BUSY_BIT] |-> st.ctrl[`ADCC_POWER_BIT];
    endproperty
    a_busy_needs_power: assert property (p_busy_needs_power) else $error("busy set while unpowered");

    property p_completion;
        (done && !SLEEP) |=> (!st.ctrl[`ADCC_BUSY_BIT] && st.flag && st.result == $past(dac_dec));
    endproperty
    a_completion: assert property (p_completion) else $error("completion event incomplete");

    property p_hold_disconnected;
        (st.state == adcc_pkg::ST_HOLD) |-> !SAMPLE;
    endproperty
    a_hold_disconnected: assert property (p_hold_disconnected) else $error("sampler on during hold");

    property p_hold_length;
        ($past(st.state) == adcc_pkg::ST_HOLD && st.state == adcc_pkg::ST_IDLE && st.ctrl[`ADCC_POWER_BIT])
            |-> ($past(st.cnt) == `ADCC_HOLD_HALVES - 5'd1);
    endproperty
    a_hold_length: assert property (p_hold_length) else $error("hold left early");

    property p_abort_keeps_result;
        (st.state == adcc_pkg::ST_CONV && !done && !(take && AVS_WRITE && idx == `ADCC_IDX_RESULT))
            |=> $stable(st.result);
    endproperty
    a_abort_keeps_result: assert property (p_abort_keeps_result) else $error("result changed mid conversion");

    property p_port_zero;
        (take && AVS_READ && idx == `ADCC_IDX_PORT) |-> ((AVS_READDATA[3:0] & ANALOG_PINS) == 4'h0);
    endproperty
    a_port_zero: assert property (p_port_zero) else $error("analog pin read nonzero");

    property p_power_off;
        !st.ctrl[`ADCC_POWER_BIT] |-> (!ANALOG_ENABLE && !SAMPLE && st.state == adcc_pkg::ST_IDLE);
    endproperty
    a_power_off: assert property (p_power_off) else $error("converter active while off");

    property p_conv_length;
        (st.state == adcc_pkg::ST_CONV) |-> (st.cnt < `ADCC_CONV_HALVES);
    endproperty
    a_conv_length: assert property (p_conv_length) else $error("conversion overran");

    property p_rc_wait;
        $rose(st.state == adcc_pkg::ST_RCWAIT) |-> (st.state == adcc_pkg::ST_RCWAIT && !half_tick)[*1] ##1
            (st.state != adcc_pkg::ST_CONV)[*3];
    endproperty
    a_rc_wait: assert property (p_rc_wait) else $error("rc wait too short");

    property p_wake;
        (done && SLEEP && st.irq_en) |=> (WAKE && !st.sleep_off);
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on completion");

    property p_flag_sticky;
        (st.flag && !(take && AVS_WRITE && idx == `ADCC_IDX_STATUS)) |=> st.flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared by hardware");

endmodule

/* File: test/adcc_analog_model.sv */
// Analog side of the converter: four input sources, the hold capacitor, comparator and RC clock.
// Assumes the block's sample, channel and trial code outputs and a source level vector from the bench.
module adcc_analog_model (
    input  wire logic        clk,
    input  wire logic        sample,
    input  wire logic [1:0]  chan,
    input  wire logic [7:0]  dac,
    input  wire logic [31:0] vin,
    output logic             comp,
    output logic             rc_clk
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] held;

    // The capacitor charges only while connected and keeps its charge otherwise, so stale values show.
    always @(posedge clk) begin
        if (sample === 1'b1) begin
            held <= vin[chan * 8 +: 8];
        end
    end

    // The comparator keeps the trial bit when the held level is at or above the code.
    assign comp = (held >= dac);

    // The RC clock runs free at a period unrelated to the system clock.
    initial begin
        held = 8'hA5;
        rc_clk = 1'b0;
    end
    always #37 rc_clk = ~rc_clk;
endmodule

/* File: test/testbench.sv */
// Self-checking bench for the converter control block, driven over its register bus.
// Assumes the analog model beside the block; reads are checked against a queue of expected values.
`include "adcc_defines.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        SYS_CLK = 1'b0, RESET_N = 1'b0, AVS_READ = 1'b0, AVS_WRITE = 1'b0, SLEEP = 1'b0, want = 1'b0;
    logic [9:0]  AVS_ADDRESS = 10'h000;
    logic [31:0] AVS_WRITEDATA = 32'h0, vin, AVS_READDATA, e;
    logic [3:0]  PIN_IN = 4'h0, ANALOG_PINS;
    logic        AVS_WAITREQUEST, COMP_IN, RC_CLK, ANALOG_ENABLE, SAMPLE, REF_FROM_PIN, WAKE, r;
    logic [1:0]  CHANNEL;
    logic [7:0]  DAC_CODE;
    logic [3:0]  amap [8] = '{4'hF, 4'hD, 4'h7, 4'h5, 4'h3, 4'h1, 4'h1, 4'h0};
    logic [31:0] expq [$];
    int          err_count = 0, n_checks = 0, seed = 96, n;

    adcc_top i_dut (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
        .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST), .SLEEP(SLEEP), .RC_CLK(RC_CLK), .COMP_IN(COMP_IN), .PIN_IN(PIN_IN),
        .ANALOG_ENABLE(ANALOG_ENABLE), .SAMPLE(SAMPLE), .CHANNEL(CHANNEL), .DAC_CODE(DAC_CODE),
        .ANALOG_PINS(ANALOG_PINS), .REF_FROM_PIN(REF_FROM_PIN), .WAKE(WAKE));
    adcc_analog_model i_model (.clk(SYS_CLK), .sample(SAMPLE), .chan(CHANNEL), .dac(DAC_CODE), .vin(vin),
        .comp(COMP_IN), .rc_clk(RC_CLK));

    always #5 SYS_CLK = ~SYS_CLK;

    // One bus cycle, held until waitrequest is seen low at an edge; reads leave their expectation queued.
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        @(posedge SYS_CLK);
        AVS_ADDRESS <= {idx, 2'b00};
        AVS_WRITEDATA <= {24'h0, d};
        AVS_WRITE <= wr;
        AVS_READ <= ~wr;
        want <= ~wr;
        if (!wr) expq.push_back({24'h0, d});
        @(posedge SYS_CLK iff AVS_WAITREQUEST === 1'b0);
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
        want <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d); xfer(1'b1, idx, d); endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] d); xfer(1'b0, idx, d); endtask

    // Compares read data with the oldest note at the edge the read completes.
    always @(posedge SYS_CLK) begin
        if (AVS_READ && want && AVS_WAITREQUEST === 1'b0) begin
            e = expq.pop_front();
            `CHK(AVS_READDATA, e)
        end
    end

    // One conversion with settling time; the low span of SAMPLE covers conversion plus hold-off.
    task automatic conv(input logic [1:0] cs, input logic [1:0] ch);
        int h;
        h = (cs == 2'h0) ? 1 : (cs == 2'h1) ? 4 : 16;
        wr(`ADCC_IDX_CTRL, {cs, 1'b0, ch, 3'b001});
        repeat (10) @(posedge SYS_CLK);
        wr(`ADCC_IDX_CTRL, {cs, 1'b0, ch, 3'b101});
        n = 0;
        do begin
            @(posedge SYS_CLK);
            n++;
        end while (SAMPLE !== 1'b1 && n < 3000);
        if (cs != `ADCC_CLK_RC) `CHK(n >= 23 * h && n <= 24 * h + 3, 1'b1)
        `CHK(CHANNEL, ch)
        `CHK(DAC_CODE, vin[ch * 8 +: 8])
        rd(`ADCC_IDX_CTRL, {cs, 1'b0, ch, 3'b001});
        rd(`ADCC_IDX_RESULT, vin[ch * 8 +: 8]);
        rd(`ADCC_IDX_STATUS, 8'h01);
        rd(`ADCC_IDX_STATUS, 8'h01);
        wr(`ADCC_IDX_STATUS, 8'h00);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // A hang is cut short well after the whole sequence should have ended.
    initial begin
        #300000;
        err_count++;
        conclude;
    end

    // Main sequence: reset state, pin maps, conversions on every clock, abort, sleep and wake.
    initial begin
        vin = $random(seed);
        repeat (2) @(posedge SYS_CLK);
        RESET_N <= 1'b1;
        rd(`ADCC_IDX_CTRL, 8'h00);
        rd(`ADCC_IDX_PINCFG, 8'h00);
        rd(8'h40, 8'h00);
        `CHK(ANALOG_PINS, 4'hF)
        wr(`ADCC_IDX_CTRL, 8'h04);
        rd(`ADCC_IDX_CTRL, 8'h00);
        `CHK(ANALOG_ENABLE, 1'b0)
        wr(`ADCC_IDX_PINCFG, 8'h07);
        rd(`ADCC_IDX_STATUS, 8'h0C);
        for (int c = 0; c < 8; c++) begin
            PIN_IN <= 4'($random(seed));
            r = (c == 1 || c == 3 || c == 5);
            wr(`ADCC_IDX_PINCFG, 8'(c));
            repeat (4) @(posedge SYS_CLK);
            `CHK(ANALOG_PINS, amap[c])
            `CHK(REF_FROM_PIN, r)
            rd(`ADCC_IDX_PORT, {4'h0, PIN_IN & ~amap[c] & ~{2'b00, r, 1'b0}});
        end
        wr(`ADCC_IDX_PINCFG, 8'h00);
        wr(`ADCC_IDX_STATUS, 8'h00);
        for (int c = 0; c < 4; c++) conv(2'(c), 2'(c));
        wr(`ADCC_IDX_RESULT, 8'h5A);
        wr(`ADCC_IDX_CTRL, 8'h49);
        repeat (10) @(posedge SYS_CLK);
        wr(`ADCC_IDX_CTRL, 8'h4D);
        repeat (20) @(posedge SYS_CLK);
        wr(`ADCC_IDX_CTRL, 8'h49);
        repeat (40) @(posedge SYS_CLK);
        rd(`ADCC_IDX_RESULT, 8'h5A);
        rd(`ADCC_IDX_STATUS, 8'h00);
        `CHK(SAMPLE, 1'b1)
        wr(`ADCC_IDX_CTRL, 8'h85);
        repeat (20) @(posedge SYS_CLK);
        SLEEP <= 1'b1;
        repeat (4) @(posedge SYS_CLK);
        `CHK(ANALOG_ENABLE, 1'b0)
        rd(`ADCC_IDX_CTRL, 8'h81);
        rd(`ADCC_IDX_STATUS, 8'h10);
        SLEEP <= 1'b0;
        wr(`ADCC_IDX_STATUS, 8'h02);
        wr(`ADCC_IDX_CTRL, 8'hD9);
        repeat (10) @(posedge SYS_CLK);
        wr(`ADCC_IDX_CTRL, 8'hDD);
        SLEEP <= 1'b1;
        n = 0;
        while (WAKE !== 1'b1 && n < 3000) begin
            @(posedge SYS_CLK);
            n++;
        end
        `CHK(WAKE, 1'b1)
        SLEEP <= 1'b0;
        rd(`ADCC_IDX_RESULT, vin[31:24]);
        rd(`ADCC_IDX_STATUS, 8'h03);
        conclude;
    end
endmodule
